// [hw/podc_pad.sv]
`timescale 1ns/10ps
`default_nettype none
// one pad driver: push-pull or open-drain, registered outputs
module podc_pad (
   input wire logic clk,
   input wire logic rstn,
   input wire logic od_en,
   input wire logic is_periph,
   input wire logic per_data,
   input wire logic per_drive,
   input wire logic output_latch,
   input wire logic direction_bits,
   output logic pad_out,
   output logic pad_oe
);
   import podc_pkg::*;
   typedef struct packed {
      logic out;
      logic oe;
   } podc_pad_s;
   podc_pad_s st_ff, nxt_st;

   // a driven one under open drain is released, the pull-up makes the high
   always_comb begin
      nxt_st = st_ff;
      if (is_periph) begin
         if (od_en) begin
            nxt_st.out = 1'b0; // RULE13
            nxt_st.oe = per_drive & ~per_data; // RULE13
         end else begin
            nxt_st.out = per_data; // RULE1
            nxt_st.oe = per_drive; // RULE1
         end
      end else begin
         nxt_st.out = output_latch;
         nxt_st.oe = ~direction_bits; // RULE12
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign pad_out = st_ff.out;
   assign pad_oe = st_ff.oe;

   property p_od_never_high;
      @(posedge clk) disable iff (!rstn) (pad_oe && $past(is_periph) && $past(od_en)) |-> !pad_out;
   endproperty
   a_od_never_high: assert property (p_od_never_high) else $error("open drain drove high"); // RULE13
   property p_od_low;
      @(posedge clk) disable iff (!rstn) (is_periph && od_en && per_drive && !per_data) |=> (pad_oe && !pad_out);
   endproperty
   a_od_low: assert property (p_od_low) else $error("open drain zero not driven"); // RULE13
   property p_pp;
      @(posedge clk) disable iff (!rstn) (is_periph && !od_en && per_drive) |=> (pad_oe && pad_out == $past(per_data));
   endproperty
   a_pp: assert property (p_pp) else $error("push pull wrong"); // RULE1
   property p_latch_zero;
      @(posedge clk) disable iff (!rstn) (!is_periph && !output_latch)
         |=> (pad_oe == !$past(direction_bits) && !pad_out);
   endproperty
   a_latch_zero: assert property (p_latch_zero) else $error("latch zero pin wrong"); // RULE12
endmodule // podc_pad
`default_nettype wire

// [hw/podc_pkg.sv]
package podc_pkg;
   // word indices of the banked registers; the bus byte address is four times the index
   localparam logic [11:0] PODC_IDX_PADCFG = 12'hf3c;
   localparam logic [11:0] PODC_IDX_OD3 = 12'hf40;
   localparam logic [11:0] PODC_IDX_OD2 = 12'hf41;
   localparam logic [11:0] PODC_IDX_OD1 = 12'hf42;
   localparam int PODC_AW = 14;
   // field positions
   localparam int PODC_OD3_DELAY_BIT = 7;
   localparam int PODC_OD3_SPI2_BIT = 1;
   localparam int PODC_OD3_SPI1_BIT = 0;
   localparam int PODC_PAD_TTL_BIT = 0;
   localparam int PODC_PAD_SEL_LO = 1;
   // write masks of implemented bits
   localparam logic [7:0] PODC_OD1_MASK = 8'hff;
   localparam logic [7:0] PODC_OD2_MASK = 8'h0f;
   localparam logic [7:0] PODC_OD3_MASK = 8'h83;
   localparam logic [7:0] PODC_PAD_MASK = 8'h07;
   localparam logic [7:0] PODC_RESET_VAL = 8'h00;
   // number of pads served by the remap unit
   localparam int PODC_NPAD = 16;
   // peripheral output indices: 0..7 od1 bits, 8..11 od2 bits, 12..13 spi
   localparam int PODC_NOUT = 14;
   // rtc pin source codes
   localparam logic [1:0] PODC_RTC_ALARM = 2'h0;
   localparam logic [1:0] PODC_RTC_SECS = 2'h1;
   localparam logic [1:0] PODC_RTC_CLKSRC = 2'h2;
   localparam logic [1:0] PODC_AXI_OKAY = 2'h0;
   localparam logic [1:0] PODC_AXI_SLVERR = 2'h2;
endpackage

// [hw/podc_top.sv]
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// RULE1: a set open-drain bit makes that module's outputs open-drain, clear means push-pull.
// RULE2: the first open-drain register holds compare 8..4 in bits 7..3 and pwm 3..1 in bits 2..0.
// RULE3: the second holds compare 10, compare 9, serial 2, serial 1 in bits 3..0, upper bits read zero.
// RULE4: the third holds spi 2 and spi 1 in bits 1..0, bits 6..2 read zero.
// RULE5: bit 7 of the third register enables the charge unit delay input on port a pin 1.
// RULE6: a remapped output gets the open-drain setting on whichever pad it is routed to.
// RULE7: open-drain acts only on serial, spi and compare/pwm data and clock outputs.
// RULE8: pad config bit 0 selects ttl buffers for all parallel port inputs, clear selects schmitt.
// RULE9: pad config bits 2..1 pick the rtc pin source: alarm, seconds, clock source, reserved.
// RULE10: the clock source is rc, secondary oscillator or external timer clock per two config bits.
// RULE11: the rtc pin carries its source only while the rtc output enable is set.
// RULE12: with latch zero a gpio pad drives low as output and floats as input.
// RULE13: open-drain pulls low for zero and releases for one, never drives high.
module podc_top (
   input wire logic clk,
   input wire logic rstn,
   // axi4-lite slave
   input wire logic [podc_pkg::PODC_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [podc_pkg::PODC_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // peripheral outputs and remap
   input wire logic [podc_pkg::PODC_NOUT-1:0] per_data,
   input wire logic [podc_pkg::PODC_NOUT-1:0] per_drive,
   input wire logic [podc_pkg::PODC_NPAD*4-1:0] pin_remap_unit,
   input wire logic [podc_pkg::PODC_NPAD-1:0] remap_valid,
   input wire logic [podc_pkg::PODC_NPAD-1:0] output_latch,
   input wire logic [podc_pkg::PODC_NPAD-1:0] direction_bits,
   output logic [podc_pkg::PODC_NPAD-1:0] pad_out,
   output logic [podc_pkg::PODC_NPAD-1:0] pad_oe,
   // misc pad controls
   output logic charge_unit_delay_input_en,
   output logic parport_ttl_input_sel,
   // rtc pin
   input wire logic rtc_alarm_pulse,
   input wire logic rtc_seconds_clk,
   input wire logic rtc_intrc_clk,
   input wire logic rtc_t1osc_clk,
   input wire logic rtc_t1cki_clk,
   input wire logic rtc_osc_source_cfg,
   input wire logic timer1_osc_enable,
   input wire logic rtc_pin_output_en,
   output logic rtc_pin_out,
   output logic rtc_pin_oe
);
   import podc_pkg::*;

   typedef enum logic [1:0] {W_IDLE, W_RESP} podc_wst_e;
   typedef enum logic [1:0] {R_IDLE, R_RESP} podc_rst_e;

   typedef struct packed {
      logic [7:0] od1;
      logic [7:0] od2;
      logic [7:0] od3;
      logic [7:0] pad;
      podc_wst_e wst;
      podc_rst_e rst;
      logic aw_got;
      logic w_got;
      logic [PODC_AW-1:0] awaddr;
      logic [7:0] wbyte;
      logic wlane;
      logic [1:0] bresp;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic rtc_out;
      logic rtc_oe;
   } podc_s;

   podc_s st_ff, nxt_st;
   logic [PODC_NOUT-1:0] od_vec;

   // word index of a byte address; registers sit one per word at index*4
   function automatic logic [11:0] podc_index(input logic [PODC_AW-1:0] a);
      podc_index = a[PODC_AW-1:2];
   endfunction

   // decode returns hit and the register byte
   function automatic logic [8:0] podc_read(input podc_s s, input logic [11:0] idx);
      case (idx)
         PODC_IDX_OD1: podc_read = {1'b1, s.od1}; // RULE2
         PODC_IDX_OD2: podc_read = {1'b1, s.od2 & PODC_OD2_MASK}; // RULE3
         PODC_IDX_OD3: podc_read = {1'b1, s.od3 & PODC_OD3_MASK}; // RULE4
         PODC_IDX_PADCFG: podc_read = {1'b1, s.pad & PODC_PAD_MASK};
         default: podc_read = 9'h000;
      endcase
   endfunction

   // bus and rtc next state
   always_comb begin
      logic [11:0] widx;
      logic [8:0] rd;
      logic [1:0] sel;
      logic clk_src;
      logic src;
      widx = 12'h000;
      rd = 9'h000;
      sel = 2'h0;
      clk_src = 1'b0;
      src = 1'b0;
      nxt_st = st_ff;
      // write channel: address and data taken in either order
      case (st_ff.wst)
         W_IDLE: begin
            if (s_axi_awvalid && !st_ff.aw_got) begin
               nxt_st.aw_got = 1'b1;
               nxt_st.awaddr = s_axi_awaddr;
            end
            if (s_axi_wvalid && !st_ff.w_got) begin
               nxt_st.w_got = 1'b1;
               nxt_st.wbyte = s_axi_wdata[7:0];
               nxt_st.wlane = s_axi_wstrb[0];
            end
            if (nxt_st.aw_got && nxt_st.w_got) begin
               widx = podc_index(nxt_st.awaddr);
               nxt_st.bresp = PODC_AXI_OKAY;
               // only lane 0 carries data; upper lanes ignored
               case (widx)
                  PODC_IDX_OD1: if (nxt_st.wlane) nxt_st.od1 = nxt_st.wbyte & PODC_OD1_MASK; // RULE2
                  PODC_IDX_OD2: if (nxt_st.wlane) nxt_st.od2 = nxt_st.wbyte & PODC_OD2_MASK; // RULE3
                  PODC_IDX_OD3: if (nxt_st.wlane) nxt_st.od3 = nxt_st.wbyte & PODC_OD3_MASK; // RULE4
                  PODC_IDX_PADCFG: if (nxt_st.wlane) nxt_st.pad = nxt_st.wbyte & PODC_PAD_MASK;
                  default: nxt_st.bresp = PODC_AXI_SLVERR;
               endcase
               nxt_st.wst = W_RESP;
            end
         end
         W_RESP: begin
            if (s_axi_bready) begin
               nxt_st.wst = W_IDLE;
               nxt_st.aw_got = 1'b0;
               nxt_st.w_got = 1'b0;
            end
         end
         default: nxt_st.wst = W_IDLE;
      endcase
      // read channel
      case (st_ff.rst)
         R_IDLE: begin
            if (s_axi_arvalid) begin
               rd = podc_read(st_ff, podc_index(s_axi_araddr));
               nxt_st.rdata = {24'h000000, rd[7:0]};
               nxt_st.rresp = rd[8] ? PODC_AXI_OKAY : PODC_AXI_SLVERR;
               nxt_st.rst = R_RESP;
            end
         end
         R_RESP: begin
            if (s_axi_rready) begin
               nxt_st.rst = R_IDLE;
            end
         end
         default: nxt_st.rst = R_IDLE;
      endcase
      // rtc pin source select; reserved code drives low
      sel = st_ff.pad[PODC_PAD_SEL_LO +: 2];
      if (!rtc_osc_source_cfg) begin
         clk_src = rtc_intrc_clk; // RULE10
      end else if (timer1_osc_enable) begin
         clk_src = rtc_t1osc_clk; // RULE10
      end else begin
         clk_src = rtc_t1cki_clk; // RULE10
      end
      case (sel)
         PODC_RTC_ALARM: src = rtc_alarm_pulse; // RULE9
         PODC_RTC_SECS: src = rtc_seconds_clk; // RULE9
         PODC_RTC_CLKSRC: src = clk_src; // RULE9
         default: src = 1'b0;
      endcase
      nxt_st.rtc_out = rtc_pin_output_en & src; // RULE11
      nxt_st.rtc_oe = rtc_pin_output_en; // RULE11
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // open-drain enable per peripheral output, only compare, pwm, serial, spi
   assign od_vec = {st_ff.od3[PODC_OD3_SPI2_BIT], st_ff.od3[PODC_OD3_SPI1_BIT], st_ff.od2[3:0], st_ff.od1}; // RULE7

   // each pad looks up the peripheral routed to it, so the setting follows the route
   genvar gi;
   generate
      for (gi = 0; gi < PODC_NPAD; gi++) begin : g_pad
         logic [3:0] src_idx;
         logic hit;
         assign src_idx = pin_remap_unit[gi*4 +: 4];
         assign hit = remap_valid[gi] && (src_idx < 4'(PODC_NOUT));
         podc_pad u_pad (
            .clk(clk),
            .rstn(rstn),
            .od_en(hit && od_vec[src_idx]), // RULE6
            .is_periph(hit),
            .per_data(hit && per_data[src_idx]),
            .per_drive(hit && per_drive[src_idx]),
            .output_latch(output_latch[gi]),
            .direction_bits(direction_bits[gi]),
            .pad_out(pad_out[gi]),
            .pad_oe(pad_oe[gi])
         );
      end
   endgenerate

   assign charge_unit_delay_input_en = st_ff.od3[PODC_OD3_DELAY_BIT]; // RULE5
   assign parport_ttl_input_sel = st_ff.pad[PODC_PAD_TTL_BIT]; // RULE8
   assign rtc_pin_out = st_ff.rtc_out;
   assign rtc_pin_oe = st_ff.rtc_oe;
   assign s_axi_awready = (st_ff.wst == W_IDLE) && !st_ff.aw_got;
   assign s_axi_wready = (st_ff.wst == W_IDLE) && !st_ff.w_got;
   assign s_axi_bvalid = (st_ff.wst == W_RESP);
   assign s_axi_bresp = st_ff.bresp;
   assign s_axi_arready = (st_ff.rst == R_IDLE);
   assign s_axi_rvalid = (st_ff.rst == R_RESP);
   assign s_axi_rdata = st_ff.rdata;
   assign s_axi_rresp = st_ff.rresp;

   property p_od2_upper;
      @(posedge clk) disable iff (!rstn) s_axi_rvalid && $past(s_axi_arvalid && s_axi_arready)
         && podc_index($past(s_axi_araddr)) == PODC_IDX_OD2 |-> s_axi_rdata[31:4] == 28'h0;
   endproperty
   a_od2_upper: assert property (p_od2_upper) else $error("od2 upper bits not zero"); // RULE3
   property p_od3_gap;
      @(posedge clk) disable iff (!rstn) s_axi_rvalid && $past(s_axi_arvalid && s_axi_arready)
         && podc_index($past(s_axi_araddr)) == PODC_IDX_OD3 |-> s_axi_rdata[6:2] == 5'h0;
   endproperty
   a_od3_gap: assert property (p_od3_gap) else $error("od3 gap bits not zero"); // RULE4
   property p_rtc_off;
      @(posedge clk) disable iff (!rstn) !rtc_pin_output_en |=> (!rtc_pin_oe && !rtc_pin_out);
   endproperty
   a_rtc_off: assert property (p_rtc_off) else $error("rtc pin active while disabled"); // RULE11
   property p_rtc_secs;
      @(posedge clk) disable iff (!rstn) (rtc_pin_output_en && st_ff.pad[PODC_PAD_SEL_LO +: 2] == PODC_RTC_SECS)
         |=> rtc_pin_out == $past(rtc_seconds_clk);
   endproperty
   a_rtc_secs: assert property (p_rtc_secs) else $error("rtc seconds source wrong"); // RULE9
   property p_rtc_intrc;
      @(posedge clk) disable iff (!rstn) (rtc_pin_output_en && st_ff.pad[PODC_PAD_SEL_LO +: 2] == PODC_RTC_CLKSRC
         && !rtc_osc_source_cfg)
         |=> rtc_pin_out == $past(rtc_intrc_clk);
   endproperty
   a_rtc_intrc: assert property (p_rtc_intrc) else $error("rtc clock source wrong"); // RULE10
   property p_wr_od1;
      @(posedge clk) disable iff (!rstn) (s_axi_bvalid && !$past(s_axi_bvalid) && st_ff.bresp == PODC_AXI_OKAY
         && podc_index(st_ff.awaddr) == PODC_IDX_OD1 && st_ff.wlane) |-> st_ff.od1 == st_ff.wbyte;
   endproperty
   a_wr_od1: assert property (p_wr_od1) else $error("od1 write lost"); // RULE2
   // a pad config write must reach the buffer select pin in the cycle its response appears
   property p_ttl;
      @(posedge clk) disable iff (!rstn) (s_axi_bvalid && !$past(s_axi_bvalid) && st_ff.bresp == PODC_AXI_OKAY
         && podc_index(st_ff.awaddr) == PODC_IDX_PADCFG && st_ff.wlane)
         |-> parport_ttl_input_sel == st_ff.wbyte[PODC_PAD_TTL_BIT];
   endproperty
   a_ttl: assert property (p_ttl) else $error("ttl select moved"); // RULE8
   property p_delay;
      @(posedge clk) disable iff (!rstn) (s_axi_bvalid && !$past(s_axi_bvalid) && st_ff.bresp == PODC_AXI_OKAY
         && podc_index(st_ff.awaddr) == PODC_IDX_OD3 && st_ff.wlane)
         |-> charge_unit_delay_input_en == st_ff.wbyte[PODC_OD3_DELAY_BIT];
   endproperty
   a_delay: assert property (p_delay) else $error("delay enable missing"); // RULE5
   property p_bresp_hold;
      @(posedge clk) disable iff (!rstn) s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
   endproperty
   a_bresp_hold: assert property (p_bresp_hold) else $error("bvalid dropped");
   c_write: cover property (@(posedge clk) disable iff (!rstn) s_axi_bvalid && s_axi_bready);
   c_read: cover property (@(posedge clk) disable iff (!rstn) s_axi_rvalid && s_axi_rready);
   c_od: cover property (@(posedge clk) disable iff (!rstn) |(od_vec & per_drive));
   c_rtc: cover property (@(posedge clk) disable iff (!rstn) rtc_pin_oe && st_ff.pad[2:1] == PODC_RTC_CLKSRC);
endmodule // podc_top
`default_nettype wire

// [verif/pad_open_drain_config_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module pad_open_drain_config_tb_top;
   import podc_pkg::*;
   logic clk, rstn;
   logic [13:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [13:0] per_data, per_drive;
   logic [63:0] pin_remap_unit;
   logic [15:0] remap_valid, output_latch, direction_bits, pad_out, pad_oe, pad_level;
   logic charge_unit_delay_input_en, parport_ttl_input_sel, rtc_pin_out, rtc_pin_oe;
   logic rtc_alarm_pulse, rtc_seconds_clk, rtc_intrc_clk, rtc_t1osc_clk, rtc_t1cki_clk;
   logic rtc_osc_source_cfg, timer1_osc_enable, rtc_pin_output_en;
   // register model in order od1, od2, od3, pad config
   logic [13:0] addr_t [4] = '{14'h3d08, 14'h3d04, 14'h3d00, 14'h3cf0};
   logic [7:0] mask_t [4] = '{8'hff, 8'h0f, 8'h83, 8'h07};
   logic [7:0] m_reg [4];
   logic [15:0] seed;
   logic [1:0] resp;
   logic [31:0] rd;
   int fail_count = 0;
   int cmp_count = 0;
   int cyc = 0;

   podc_top i_podc_top (.clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .per_data, .per_drive, .pin_remap_unit, .remap_valid, .output_latch,
      .direction_bits, .pad_out, .pad_oe, .charge_unit_delay_input_en, .parport_ttl_input_sel,
      .rtc_alarm_pulse, .rtc_seconds_clk, .rtc_intrc_clk, .rtc_t1osc_clk, .rtc_t1cki_clk,
      .rtc_osc_source_cfg, .timer1_osc_enable, .rtc_pin_output_en, .rtc_pin_out, .rtc_pin_oe);
   podc_pad_far i_podc_pad_far (.pad_out, .pad_oe, .pad_level);

   // 16-bit lfsr, seeded with 21942 below
   function automatic logic [15:0] rnd();
      seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
      return seed;
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one write; payload held until each channel is taken, model follows the slave
   task automatic axw(input logic [13:0] a, input logic [31:0] d);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (!(s_axi_bvalid && s_axi_bready));
      resp = s_axi_bresp;
      s_axi_bready <= 1'h0;
      // only lane 0 carries the register byte
      for (int k = 0; k < 4; k++) if (a == addr_t[k] && s_axi_wstrb[0]) m_reg[k] = d[7:0] & mask_t[k];
   endtask

   task automatic axr(input logic [13:0] a);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (!(s_axi_rvalid && s_axi_rready));
      resp = s_axi_rresp;
      rd = s_axi_rdata;
      s_axi_rready <= 1'h0;
   endtask

   task automatic check_reg(input int k);
      axr(addr_t[k]);
      chk(32'(resp), 32'h0);
      chk(rd, {24'h0, m_reg[k]});
   endtask

   // random routing and levels; gpio pads ride along so stray open-drain effects show up
   task automatic pads_once();
      logic [31:0] w;
      logic [63:0] m;
      logic [13:0] od;
      logic [3:0] p;
      logic eo, eoe;
      for (int k = 0; k < 3; k++) axw(addr_t[k], {rnd(), rnd()});
      for (int i = 0; i < 16; i++) m[4*i +: 4] = 4'(rnd() % 16'h000e);
      @(posedge clk);
      w = {rnd(), rnd()};
      per_data <= w[13:0];
      per_drive <= w[27:14];
      remap_valid <= rnd();
      output_latch <= rnd();
      direction_bits <= rnd();
      pin_remap_unit <= m;
      repeat (2) @(posedge clk);
      #1;
      od = {m_reg[2][1:0], m_reg[1][3:0], m_reg[0]};
      for (int i = 0; i < 16; i++) begin
         p = pin_remap_unit[4*i +: 4];
         if (remap_valid[i]) begin
            eo = per_data[p] & ~od[p];
            eoe = per_drive[p] & ~(od[p] & per_data[p]);
         end else begin
            eo = output_latch[i];
            eoe = ~direction_bits[i];
         end
         chk(32'({pad_out[i], pad_oe[i], pad_level[i]}), 32'({eo, eoe, eoe ? eo : 1'h1}));
      end
   endtask

   // every gate and oscillator combination for one source code
   task automatic rtc_sel(input logic [1:0] s);
      logic [15:0] v;
      logic e;
      v = rnd();
      axw(addr_t[3], {16'h0, v[15:3], s, v[0]});
      for (int c = 0; c < 8; c++) begin
         @(posedge clk);
         {rtc_pin_output_en, rtc_osc_source_cfg, timer1_osc_enable} <= 3'(c);
         {rtc_alarm_pulse, rtc_seconds_clk, rtc_intrc_clk, rtc_t1osc_clk, rtc_t1cki_clk} <= 5'(rnd());
         repeat (2) @(posedge clk);
         #1;
         case (s)
            2'h0: e = rtc_alarm_pulse;
            2'h1: e = rtc_seconds_clk;
            2'h2: e = rtc_osc_source_cfg ? (timer1_osc_enable ? rtc_t1osc_clk : rtc_t1cki_clk) : rtc_intrc_clk;
            default: e = 1'h0;
         endcase
         chk(32'({rtc_pin_out, rtc_pin_oe}), 32'({e & rtc_pin_output_en, rtc_pin_output_en}));
      end
      chk(32'(parport_ttl_input_sel), 32'(v[0]));
   endtask

   task automatic close_out();
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   initial begin
      clk = 1'h0;
      forever #4 clk = ~clk;
   end

   // hang guard, far above the roughly 500 cycles the sequence needs
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         close_out();
      end
   end

   initial begin
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, per_data, per_drive, pin_remap_unit} = '0;
      {remap_valid, output_latch, direction_bits, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready, rtc_alarm_pulse, rtc_seconds_clk, rtc_intrc_clk} = '0;
      {rtc_t1osc_clk, rtc_t1cki_clk, rtc_osc_source_cfg, timer1_osc_enable, rtc_pin_output_en} = '0;
      s_axi_wstrb = 4'hf;
      seed = 16'h55b6;
      m_reg = '{default: 8'h00};
      rstn = 1'h0;
      repeat (2) @(posedge clk);
      rstn <= 1'h1;
      // reset contents, then unused words inside the bank
      for (int k = 0; k < 4; k++) check_reg(k);
      chk(32'({charge_unit_delay_input_en, parport_ttl_input_sel, rtc_pin_oe}), 32'h0);
      axr(14'h3cfc);
      chk(32'(resp), 32'h2);
      chk(rd, 32'h0);
      axw(14'h3cf4, 32'hffffffff);
      chk(32'(resp), 32'h2);
      $display("test reset_map done");
      // random then all-ones writes; unimplemented bits must read back zero
      for (int n = 0; n < 2; n++) begin
         for (int k = 0; k < 4; k++) begin
            axw(addr_t[k], (n == 1) ? 32'hffffffff : {rnd(), rnd()});
            chk(32'(resp), 32'h0);
         end
         for (int k = 0; k < 4; k++) check_reg(k);
         chk(32'({charge_unit_delay_input_en, parport_ttl_input_sel}), 32'({m_reg[2][7], m_reg[3][0]}));
      end
      // lane 0 strobe off: the byte must not land
      s_axi_wstrb <= 4'he;
      axw(addr_t[0], 32'h00000000);
      chk(32'(resp), 32'h0);
      s_axi_wstrb <= 4'hf;
      check_reg(0);
      // reset in mid-run must clear every register that was just set
      @(posedge clk);
      rstn <= 1'h0;
      repeat (2) @(posedge clk);
      rstn <= 1'h1;
      m_reg = '{default: 8'h00};
      for (int k = 0; k < 4; k++) check_reg(k);
      chk(32'({charge_unit_delay_input_en, parport_ttl_input_sel}), 32'h0);
      $display("test regs done");
      repeat (24) pads_once();
      $display("test pads done");
      for (int s = 0; s < 4; s++) rtc_sel(2'(s));
      $display("test rtc done");
      close_out();
   end
endmodule // pad_open_drain_config_tb_top
`default_nettype wire

// [verif/podc_pad_far.sv]
`timescale 1ns/10ps
`default_nettype none
// far side: higher-voltage logic that sees every pad line through a pull-up
module podc_pad_far (
   input wire logic [podc_pkg::PODC_NPAD-1:0] pad_out,
   input wire logic [podc_pkg::PODC_NPAD-1:0] pad_oe,
   output logic [podc_pkg::PODC_NPAD-1:0] pad_level
);
   import podc_pkg::*;
   // a released line floats up to the external rail, never to the last driven value
   always_comb begin
      for (int i = 0; i < PODC_NPAD; i++) begin
         pad_level[i] = pad_oe[i] ? pad_out[i] : 1'h1;
      end
   end
endmodule // podc_pad_far
`default_nettype wire
